//--- design/flash_guard_pkg.sv
// Package: constants and carrier types for the flash section access guard
package flash_guard_pkg;

    // Flash geometry in words
    localparam int          PC_W            = 12;           // Word address width
    localparam logic [11:0] STALL_START     = 12'hc00;      // First stalling-part word
    // Boot part start per boot-size fuse value (fuse bits 1 = unprogrammed)
    localparam logic [11:0] BOOT_START_11   = 12'hf80;
    localparam logic [11:0] BOOT_START_10   = 12'hf00;
    localparam logic [11:0] BOOT_START_01   = 12'he00;
    localparam logic [11:0] BOOT_START_00   = 12'hc00;

    // Programming busy time
    localparam int          PROG_TIME_NS    = 4500000;      // Page erase or write time, ns
    localparam int          CLK_PERIOD_NS   = 25;
    localparam int          PROG_CYCLES     = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int          CNT_W           = 18;
    localparam logic [CNT_W-1:0] CNT_ZERO   = 18'h00000;
    localparam logic [CNT_W-1:0] CNT_ONE    = 18'h00001;

    // Lock bits after reset: unprogrammed
    localparam logic [1:0]  LOCK_RESET      = 2'h3;

    // Program-store kinds
    typedef enum logic [1:0] {
        OP_BUF_LOAD = 2'b00,   // Page-buffer load
        OP_ERASE    = 2'b01,   // Page erase
        OP_WRITE    = 2'b10,   // Page write
        OP_REENABLE = 2'b11    // Re-enable concurrent-read part
    } store_kind_t;

    // Program-store request from the core
    typedef struct packed {
        logic               valid;   // One-cycle request
        store_kind_t        kind;    // Operation kind
        logic [PC_W-1:0]    pc;      // Program counter of issuing code
        logic [PC_W-1:0]    addr;    // Target word address
    } store_req_t;

    // Program-load request from the core
    typedef struct packed {
        logic               valid;   // One-cycle request
        logic [PC_W-1:0]    pc;      // Program counter of issuing code
        logic [PC_W-1:0]    addr;    // Target word address
    } load_req_t;

    // Guard states
    typedef enum logic [1:0] {
        ST_IDLE     = 2'b00,   // No programming
        ST_CONC     = 2'b01,   // Concurrent-read part programming
        ST_STALL    = 2'b10    // Stalling part programming, core halted
    } guard_state_t;

endpackage

//--- design/prog_timer.sv
// Module: down counter timing one page erase or write
`timescale 1ns/10ps
`default_nettype none

module prog_timer
    import flash_guard_pkg::*;
#(
    parameter int PROG_LEN = PROG_CYCLES   // Busy length in cycles
) (
    // Clock and reset
    input  wire logic  clk_i,
    input  wire logic  rst_n_i,
    // Control
    input  wire logic  start_i,
    // Status
    output logic       busy_o,
    output logic       done_o
);

    logic [CNT_W-1:0] count;        // Remaining cycles
    logic [CNT_W-1:0] next_count;
    logic             done;         // Registered end pulse
    logic             next_done;

    // Load on start, count down, pulse in the cycle after the last busy cycle
    always_comb begin
        next_count = count;
        next_done  = 1'b0;
        if (start_i) begin
            next_count = CNT_W'(PROG_LEN);
        end else if (count != CNT_ZERO) begin
            next_count = count - CNT_ONE;
            next_done  = (count == CNT_ONE);
        end
    end

    // Register stage
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            count <= CNT_ZERO;
            done  <= 1'b0;
        end else begin
            count <= next_count;
            done  <= next_done;
        end
    end

    assign busy_o = (count != CNT_ZERO);
    assign done_o = done;

endmodule

`default_nettype wire

//--- design/flash_section_access_guard.sv
// Module: flash self-programming access guard and core stall control
// Behaviour
// R1 - Stores from application code are ignored
// R2 - Erase/write start only from boot code
// R3 - Boot code may target whole flash
// R4 - Separate locks, boundary from boot-size fuses
// R5 - Concurrent-part programming keeps core running
// R6 - Stalling-part programming halts core, no reads
// R7 - Stall chosen from target page address
// R8 - Boot part always inside stalling part
// R9 - Busy bit high while concurrent part blocked
// R10 - Software clears busy before concurrent fetches
// R11 - Software avoids concurrent part during programming
// R12 - Two independent lock sets, app and boot
// R13 - Locks set by software, cleared by erase
// R14 - General write lock ignores program stores
// R15 - General read/write lock ignores core access
// R16 - App mode 1 no restriction
// R17 - App mode 2 refuses stores
// R18 - App mode 3 refuses stores, boot loads
// R19 - App mode 4 refuses boot loads only
// R20 - Modes 3/4 suppress interrupts across parts
// R21 - Boot locks mirror the application modes
// R22 - Lock bits: 1 unprogrammed, 0 programmed
// R23 - Busy clears on reenable or buffer load
// R24 - Executing part from PC versus boundary
// R25 - Refused operations complete silently
`timescale 1ns/10ps
`default_nettype none

module flash_section_access_guard
    import flash_guard_pkg::*;
#(
    parameter int PROG_LEN = PROG_CYCLES   // Shorten in simulation
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Configuration fuses and general lock
    input  wire logic [1:0]  boot_size_fuses_i,
    input  wire logic        vectors_in_boot_i,
    input  wire logic [1:0]  general_lock_i,
    // Lock programming
    input  wire logic        lock_set_i,
    input  wire logic [3:0]  lock_data_i,
    input  wire logic        chip_erase_i,
    // Core requests
    input  wire store_req_t  store_req_i,
    input  wire load_req_t   load_req_i,
    input  wire logic [11:0] fetch_pc_i,
    // Flash array controls
    output logic             flash_erase_o,
    output logic             flash_write_o,
    output logic             buf_load_o,
    output logic [11:0]      flash_addr_o,
    output logic             load_grant_o,
    // Core controls and status
    output logic             core_halt_o,
    output logic             irq_block_o,
    output logic             concurrent_read_busy_o,
    output logic [3:0]       lock_bits_o
);

    // Lock bit sets, 1 = unprogrammed
    logic [1:0]   app_lock;         // {app_lock_high, app_lock_low}
    logic [1:0]   boot_lock;        // {boot_lock_high, boot_lock_low}
    logic [1:0]   next_app_lock;
    logic [1:0]   next_boot_lock;
    // Programming sequence
    guard_state_t state;
    guard_state_t next_state;
    logic         busy_flag;        // Concurrent part blocked
    logic         next_busy_flag;
    // Registered array strobes and address
    logic         erase_q;
    logic         write_q;
    logic         load_q;
    logic         grant_q;
    logic [11:0]  addr_q;
    logic         next_erase;
    logic         next_write;
    logic         next_load;
    logic         next_grant;
    logic [11:0]  next_addr;
    // Decode helpers
    logic [11:0]  boot_start;
    logic         st_from_boot;
    logic         ld_from_boot;
    logic         tgt_boot;
    logic         tgt_stall;
    logic         ld_tgt_boot;
    logic         store_ok;
    logic         load_ok;
    logic         prog_start;
    logic         timer_busy;
    logic         timer_done;

    // Boot boundary from fuses; every start sits at or above the stall start
    always_comb begin
        if (boot_size_fuses_i == 2'b11) begin
            boot_start = BOOT_START_11;   // [R4] [R8]
        end else if (boot_size_fuses_i == 2'b10) begin
            boot_start = BOOT_START_10;
        end else if (boot_size_fuses_i == 2'b01) begin
            boot_start = BOOT_START_01;
        end else begin
            boot_start = BOOT_START_00;
        end
    end

    // Executing part from the issuing PC
    assign st_from_boot = (store_req_i.pc >= boot_start);     // [R24]
    assign ld_from_boot = (load_req_i.pc >= boot_start);      // [R24]
    assign tgt_boot     = (store_req_i.addr >= boot_start);
    assign tgt_stall    = (store_req_i.addr >= STALL_START);   // [R7]
    assign ld_tgt_boot  = (load_req_i.addr >= boot_start);

    // Store permission: general lock never consulted
    always_comb begin
        store_ok = 1'b0;
        if (st_from_boot) begin                                // [R1] [R2] [R3]
            if (tgt_boot) begin
                store_ok = boot_lock[0];                       // [R21] [R22]
            end else begin
                store_ok = app_lock[0];                        // [R16] [R17] [R18] [R19] [R14]
            end
        end
    end

    // Load permission: cross-part reads gated by the high lock bit
    always_comb begin
        load_ok = 1'b1;                                         // [R15]
        if (ld_from_boot && !ld_tgt_boot) begin
            load_ok = app_lock[1];                              // [R18] [R19]
        end else if (!ld_from_boot && ld_tgt_boot) begin
            load_ok = boot_lock[1];                             // [R21]
        end
        if (state == ST_STALL) begin
            load_ok = 1'b0;                                     // [R6]
        end else if (busy_flag && load_req_i.addr < STALL_START) begin
            load_ok = 1'b0;                                     // [R5] [R9]
        end
    end

    assign prog_start = store_req_i.valid && store_ok && (state == ST_IDLE) &&
                        (store_req_i.kind == OP_ERASE || store_req_i.kind == OP_WRITE);

    // Page erase/write timing
    prog_timer #(
        .PROG_LEN (PROG_LEN)
    ) u_timer (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .start_i  (prog_start),
        .busy_o   (timer_busy),
        .done_o   (timer_done)
    );

    // Lock bits: software may only program (clear to 0); erase restores 1
    always_comb begin
        next_app_lock  = app_lock;
        next_boot_lock = boot_lock;
        if (chip_erase_i) begin
            next_app_lock  = LOCK_RESET;                        // [R13]
            next_boot_lock = LOCK_RESET;
        end else if (lock_set_i) begin
            next_app_lock  = app_lock & lock_data_i[1:0];       // [R12] [R13]
            next_boot_lock = boot_lock & lock_data_i[3:2];
        end
    end

    // Programming state, busy flag and array strobes
    always_comb begin
        next_state     = state;
        next_busy_flag = busy_flag;
        next_erase     = 1'b0;
        next_write     = 1'b0;
        next_load      = 1'b0;
        next_grant     = load_req_i.valid && load_ok;           // [R25]
        next_addr      = addr_q;
        case (state)
            ST_IDLE: begin
                if (prog_start) begin
                    next_erase = (store_req_i.kind == OP_ERASE);
                    next_write = (store_req_i.kind == OP_WRITE);
                    next_addr  = store_req_i.addr;
                    if (tgt_stall) begin
                        next_state = ST_STALL;                  // [R6] [R7]
                    end else begin
                        next_state     = ST_CONC;               // [R5]
                        next_busy_flag = 1'b1;                  // [R9]
                    end
                end else if (store_req_i.valid && st_from_boot) begin
                    if (store_req_i.kind == OP_BUF_LOAD) begin
                        next_load      = 1'b1;
                        next_addr      = store_req_i.addr;
                        next_busy_flag = 1'b0;                  // [R23]
                    end else if (store_req_i.kind == OP_REENABLE) begin
                        next_busy_flag = 1'b0;                  // [R23] [R10]
                    end
                end
            end
            ST_CONC: begin
                // Reenable refused while the array is busy
                if (timer_done) begin
                    next_state = ST_IDLE;
                end
            end
            ST_STALL: begin
                if (timer_done) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Register stage
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            app_lock  <= LOCK_RESET;
            boot_lock <= LOCK_RESET;
            state     <= ST_IDLE;
            busy_flag <= 1'b0;
            erase_q   <= 1'b0;
            write_q   <= 1'b0;
            load_q    <= 1'b0;
            grant_q   <= 1'b0;
            addr_q    <= 12'h000;
        end else begin
            app_lock  <= next_app_lock;
            boot_lock <= next_boot_lock;
            state     <= next_state;
            busy_flag <= next_busy_flag;
            erase_q   <= next_erase;
            write_q   <= next_write;
            load_q    <= next_load;
            grant_q   <= next_grant;
            addr_q    <= next_addr;
        end
    end

    // Interrupt suppression when vectors sit in the other part
    always_comb begin
        irq_block_o = 1'b0;
        if (vectors_in_boot_i && fetch_pc_i < boot_start && !app_lock[1]) begin
            irq_block_o = 1'b1;                                 // [R20]
        end else if (!vectors_in_boot_i && fetch_pc_i >= boot_start && !boot_lock[1]) begin
            irq_block_o = 1'b1;                                 // [R21]
        end
    end

    // Outputs
    assign flash_erase_o          = erase_q;
    assign flash_write_o          = write_q;
    assign buf_load_o             = load_q;
    assign flash_addr_o           = addr_q;
    assign load_grant_o           = grant_q;
    assign core_halt_o            = (state == ST_STALL);       // [R6]
    assign concurrent_read_busy_o = busy_flag;                 // [R9]
    assign lock_bits_o            = {boot_lock, app_lock};     // [R22]

    // Store from application code never starts the array
    a_app_store_ignored: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R1]
        (store_req_i.valid && store_req_i.pc < boot_start && state == ST_IDLE)
        |=> !flash_erase_o && !flash_write_o && !buf_load_o)
        else $error("store from application part was not ignored");

    // Stalling-part programming halts the core; busy untouched, it may guard an older write
    a_stall_halt: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R6]
        (prog_start && tgt_stall) |=> core_halt_o && $stable(concurrent_read_busy_o))
        else $error("stalling part programming did not halt core");

    // Concurrent-part programming keeps the core running, busy set
    a_conc_busy: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R5]
        (prog_start && !tgt_stall) |=> !core_halt_o && concurrent_read_busy_o)
        else $error("concurrent part programming mishandled");

    // No load granted during a halt
    a_halt_no_read: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R6]
        core_halt_o |=> !load_grant_o)
        else $error("load granted while core halted");

    // Timer quiet whenever idle; a leftover count would pulse done with no operation running
    a_timer_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R6]
        (state == ST_IDLE) |-> !timer_busy)
        else $error("programming timer running while idle");

    // Busy bit holds until a clearing operation
    a_busy_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R9]
        (concurrent_read_busy_o && !store_req_i.valid) |=> concurrent_read_busy_o)
        else $error("busy bit dropped without clearing operation");

    // Buffer load clears busy
    a_load_clears: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R23]
        (state == ST_IDLE && store_req_i.valid && st_from_boot
         && store_req_i.kind == OP_BUF_LOAD) |=> !concurrent_read_busy_o && buf_load_o)
        else $error("buffer load did not clear busy");

    // App mode 2 refuses writes to the application part
    a_app_mode2: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R17]
        (app_lock == 2'b10 && store_req_i.valid && !tgt_boot)
        |=> !flash_write_o && !flash_erase_o)
        else $error("store to locked application part accepted");

    // Boot code load of application part refused in modes 3 and 4
    a_app_read_lock: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R19]
        (!app_lock[1] && load_req_i.valid && ld_from_boot && !ld_tgt_boot)
        |=> !load_grant_o)
        else $error("boot load of locked application part granted");

    // Application low lock bit never returns to unprogrammed without erase
    a_lock_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R13]
        (!chip_erase_i && !app_lock[0]) |=> !app_lock[0])
        else $error("lock bit cleared without chip erase");

endmodule

`default_nettype wire

//--- tb/core_model.sv
// Core model: issues program-store and program-load requests to the guard
`timescale 1ns/10ps
`default_nettype none

module core_model
    import flash_guard_pkg::*;
(
    // Clock and reset
    input  wire logic     clk_i,
    input  wire logic     rst_n_i,
    // Status from the guard
    input  wire logic     busy_i,
    // Requests to the guard
    output var store_req_t store_req_o,
    output var load_req_t  load_req_o
);

    // Idle requests from time zero
    initial begin
        store_req_o = '0;
        load_req_o  = '0;
    end

    // One-cycle store request; released pc and addr flip so stale data is never live
    task automatic store_op(input store_kind_t kind, input logic [11:0] pc,
                            input logic [11:0] addr);
        while (!rst_n_i) @(posedge clk_i);
        @(posedge clk_i);
        store_req_o <= '{valid: 1'b1, kind: kind, pc: pc, addr: addr};
        @(posedge clk_i);
        store_req_o <= '{valid: 1'b0, kind: kind, pc: ~pc, addr: ~addr};
        #1;
    endtask

    // One-cycle load; never reads the concurrent part while it is busy
    task automatic load_op(input logic [11:0] pc, input logic [11:0] addr);
        while (busy_i && addr < STALL_START) @(posedge clk_i);
        @(posedge clk_i);
        load_req_o <= '{valid: 1'b1, pc: pc, addr: addr};
        @(posedge clk_i);
        load_req_o <= '{valid: 1'b0, pc: ~pc, addr: ~addr};
        #1;
    endtask

endmodule
`default_nettype wire

//--- tb/flash_section_access_guard_bench.sv
// Testbench: flash section access guard driven through a core model
`timescale 1ns/10ps
`default_nettype none

module flash_section_access_guard_bench;
    import flash_guard_pkg::*;

    localparam int PROG  = 8;      // Shortened busy time
    localparam int LIMIT = 3000;   // Cycle ceiling, run needs far fewer

    // Design inputs
    logic        clk_i;
    logic        rst_n_i;
    logic [1:0]  boot_size_fuses_i;
    logic        vectors_in_boot_i;
    logic [1:0]  general_lock_i;
    logic        lock_set_i;
    logic [3:0]  lock_data_i;
    logic        chip_erase_i;
    logic [11:0] fetch_pc_i;
    store_req_t  store_req;
    load_req_t   load_req;
    // Design outputs
    logic        flash_erase_o;
    logic        flash_write_o;
    logic        buf_load_o;
    logic [11:0] flash_addr_o;
    logic        load_grant_o;
    logic        core_halt_o;
    logic        irq_block_o;
    logic        concurrent_read_busy_o;
    logic [3:0]  lock_bits_o;
    // Bookkeeping
    int          miscompares;
    int          check_count;
    int          cycles = 0;
    logic [11:0] bs;

    flash_section_access_guard #(.PROG_LEN(PROG)) flash_section_access_guard_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .boot_size_fuses_i(boot_size_fuses_i),
        .vectors_in_boot_i(vectors_in_boot_i), .general_lock_i(general_lock_i),
        .lock_set_i(lock_set_i), .lock_data_i(lock_data_i), .chip_erase_i(chip_erase_i),
        .store_req_i(store_req), .load_req_i(load_req), .fetch_pc_i(fetch_pc_i),
        .flash_erase_o(flash_erase_o), .flash_write_o(flash_write_o),
        .buf_load_o(buf_load_o), .flash_addr_o(flash_addr_o), .load_grant_o(load_grant_o),
        .core_halt_o(core_halt_o), .irq_block_o(irq_block_o),
        .concurrent_read_busy_o(concurrent_read_busy_o), .lock_bits_o(lock_bits_o));

    core_model core_model_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .busy_i(concurrent_read_busy_o),
        .store_req_o(store_req), .load_req_o(load_req));

    // 40 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // Hang guard
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            miscompares++;
            print_verdict();
        end
    end

    // Compare a single flag
    task automatic check_bit(input string name, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Compare a word address
    task automatic check_word(input string name, input logic [11:0] exp,
                              input logic [11:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Compare the lock bits
    task automatic check_lock(input string name, input logic [3:0] exp, input logic [3:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Counts, verdict, end of run
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One lock setting: store, cross-part load and interrupt block against expectation
    task automatic lock_case(input logic [3:0] lk, input logic boot_tgt,
                             input logic st, input logic ld, input logic irq);
        logic [11:0] tgt;
        logic [11:0] lpc;
        tgt = boot_tgt ? 12'hf90 : 12'h100;
        lpc = boot_tgt ? 12'h100 : 12'hf90;
        @(posedge clk_i);
        chip_erase_i <= 1'b1;
        @(posedge clk_i);
        chip_erase_i <= 1'b0;
        lock_set_i <= 1'b1;
        lock_data_i <= lk;
        @(posedge clk_i);
        lock_set_i <= 1'b0;
        vectors_in_boot_i <= ~boot_tgt;
        fetch_pc_i <= tgt;
        #1;
        check_lock("lock_bits_o", lk, lock_bits_o);
        check_bit("irq_block_o", irq, irq_block_o);
        core_model_inst.store_op(OP_ERASE, 12'hf90, tgt);
        check_bit("flash_erase_o", st, flash_erase_o);
        repeat (PROG + 3) @(posedge clk_i);
        core_model_inst.store_op(OP_REENABLE, 12'hf90, 12'h000);
        core_model_inst.load_op(lpc, tgt + 12'h010);
        check_bit("load_grant_o", ld, load_grant_o);
    endtask

    // Main sequence
    initial begin
        miscompares = 0;
        check_count = 0;
        rst_n_i = 1'b0;
        boot_size_fuses_i = 2'h3;
        vectors_in_boot_i = 1'b1;
        general_lock_i = 2'h0;
        lock_set_i = 1'b0;
        lock_data_i = 4'hf;
        chip_erase_i = 1'b0;
        fetch_pc_i = 12'h000;
        @(posedge clk_i);
        #1;
        check_lock("lock_bits_o", 4'hf, lock_bits_o);
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        // Concurrent-part erase: only boot code may start it, core keeps running
        core_model_inst.store_op(OP_ERASE, 12'h100, 12'h100);
        check_bit("flash_erase_o", 1'b0, flash_erase_o);
        core_model_inst.store_op(OP_ERASE, 12'hf90, 12'h100);
        check_bit("flash_erase_o", 1'b1, flash_erase_o);
        check_word("flash_addr_o", 12'h100, flash_addr_o);
        check_bit("busy", 1'b1, concurrent_read_busy_o);
        check_bit("core_halt_o", 1'b0, core_halt_o);
        core_model_inst.store_op(OP_ERASE, 12'hf90, 12'h200);
        check_bit("flash_erase_o", 1'b0, flash_erase_o);
        core_model_inst.load_op(12'hf90, 12'hc40);
        check_bit("load_grant_o", 1'b1, load_grant_o);
        core_model_inst.store_op(OP_REENABLE, 12'hf90, 12'h000);
        repeat (PROG + 3) @(posedge clk_i);
        #1;
        check_bit("busy", 1'b1, concurrent_read_busy_o);
        core_model_inst.store_op(OP_REENABLE, 12'hf90, 12'h000);
        check_bit("busy", 1'b0, concurrent_read_busy_o);
        // Stalling-part write into the boot part halts the core and blocks reads
        core_model_inst.store_op(OP_WRITE, 12'hf90, 12'hf90);
        check_bit("flash_write_o", 1'b1, flash_write_o);
        check_bit("core_halt_o", 1'b1, core_halt_o);
        core_model_inst.load_op(12'hf90, 12'hc40);
        check_bit("load_grant_o", 1'b0, load_grant_o);
        repeat (PROG + 3) @(posedge clk_i);
        #1;
        check_bit("core_halt_o", 1'b0, core_halt_o);
        // Busy left set, then cleared by the first accepted buffer load
        core_model_inst.store_op(OP_ERASE, 12'hf90, 12'h100);
        repeat (PROG + 3) @(posedge clk_i);
        // Boot boundary per fuse setting, checked on both sides
        for (int f = 0; f < 4; f++) begin
            bs = (f == 3) ? BOOT_START_11 : (f == 2) ? BOOT_START_10 :
                 (f == 1) ? BOOT_START_01 : BOOT_START_00;
            @(posedge clk_i);
            boot_size_fuses_i <= f[1:0];
            core_model_inst.store_op(OP_BUF_LOAD, bs - 12'h001, 12'h040);
            check_bit("buf_load_o", 1'b0, buf_load_o);
            core_model_inst.store_op(OP_BUF_LOAD, bs, 12'h040);
            check_bit("buf_load_o", 1'b1, buf_load_o);
        end
        check_bit("busy", 1'b0, concurrent_read_busy_o);
        @(posedge clk_i);
        boot_size_fuses_i <= 2'h3;
        // General write lock from here on; it must never gate core stores
        general_lock_i <= 2'h2;
        // Application then boot lock modes
        lock_case(4'hf, 1'b0, 1'b1, 1'b1, 1'b0);
        lock_case(4'he, 1'b0, 1'b0, 1'b1, 1'b0);
        lock_case(4'hc, 1'b0, 1'b0, 1'b0, 1'b1);
        lock_case(4'hd, 1'b0, 1'b1, 1'b0, 1'b1);
        lock_case(4'hb, 1'b1, 1'b0, 1'b1, 1'b0);
        lock_case(4'h3, 1'b1, 1'b0, 1'b0, 1'b1);
        lock_case(4'h7, 1'b1, 1'b1, 1'b0, 1'b1);
        print_verdict();
    end

endmodule
`default_nettype wire
